//--- rtl/tws_pkg.sv
/*
  Shared constants for the two-wire register slave and its master end.
  Assumes both ends import this package; the link interface does not.
*/
`default_nettype none
package tws_pkg;
  // ****************************************
  // Slave addressing
  // ****************************************
  localparam logic [6:0] TWS_SLAVE_ADDR = 7'h08;
  localparam int TWS_ASEL0_BIT = 6;
  localparam int TWS_ASEL1_BIT = 5;
  localparam logic [2:0] TWS_PIN_RST = 3'h7;
  localparam logic [1:0] TWS_LINE_RST = 2'h3;
  // ****************************************
  // Device register map
  // ****************************************
  localparam int TWS_NUM_RW = 14;
  localparam logic [7:0] TWS_REG_CTRL0 = 8'h00;
  localparam logic [7:0] TWS_REG_CTRL1 = 8'h01;
  localparam logic [7:0] TWS_REG_BIAS_LO = 8'h04;
  localparam logic [7:0] TWS_REG_BIAS_HI = 8'h05;
  localparam logic [7:0] TWS_REG_ADC_SEL = 8'h0D;
  localparam logic [7:0] TWS_REG_ADC_MSB = 8'h0E;
  localparam logic [7:0] TWS_REG_ADC_LSB = 8'h0F;
  localparam logic [7:0] TWS_REG_RST = 8'h00;
  localparam int TWS_CHIP_EN_BIT = 7;
  localparam int TWS_PULLUP_BIT = 0;
  localparam int TWS_MON_SEL_HI_BIT = 1;
  localparam logic [3:0] TWS_BIT_CNT_FULL = 4'h8;
  // ****************************************
  // Master command registers (APB)
  // ****************************************
  localparam logic [31:0] TWS_APB_CMD = 32'h0000_0000;
  localparam logic [31:0] TWS_APB_STATUS = 32'h0000_0004;
  localparam logic [31:0] TWS_APB_SADDR = 32'h0000_0008;
  localparam int TWS_CMD_READ_BIT = 16;
  // ****************************************
  // Timing
  // ****************************************
  localparam int TWS_CLK_NS = 10;
  localparam int TWS_STEP_NS = 1300;
  localparam int TWS_STEP_CYC = (TWS_STEP_NS + TWS_CLK_NS - 1) / TWS_CLK_NS;
  localparam logic [7:0] TWS_STEP_LOAD = 8'(TWS_STEP_CYC - 1);
  // ****************************************
  // State encodings
  // ****************************************
  typedef enum logic [2:0] {
    TWS_D_IDLE = 3'h0,
    TWS_D_ADDR = 3'h1,
    TWS_D_REG = 3'h2,
    TWS_D_WDATA = 3'h3,
    TWS_D_ACK = 3'h4,
    TWS_D_RDATA = 3'h5,
    TWS_D_MACK = 3'h6,
    TWS_D_IGNORE = 3'h7
  } tws_dev_state_e;
  typedef enum logic [1:0] {
    TWS_H_IDLE = 2'h0,
    TWS_H_START = 2'h1,
    TWS_H_BYTE = 2'h2,
    TWS_H_STOP = 2'h3
  } tws_host_op_e;
endpackage
`default_nettype wire

//--- rtl/tws_link_if.sv
/*
  Two-wire link between master end and slave end.
  Assumes open-drain lines with pullups; a line is low while any enabled
  driver outputs low.
*/
`timescale 1ns/10ps
`default_nettype none
interface tws_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // ****************************************
  // Wired-AND line resolution
  // ****************************************
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe
  );
  modport host (
    input scl,
    input sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface
`default_nettype wire

//--- rtl/tws_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous inputs; output changes once stages two and three
  agree.
*/
`timescale 1ns/10ps
`default_nettype none
module tws_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  // ****************************************
  // Stages and filter
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          dout[i] <= RST_VAL[i];
        end else if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/tws_device.sv
/*
  Two-wire register slave: 16 byte registers, one byte per transfer.
  Assumes a master that drives the serial clock; runs on the link clock.
*/
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module tws_device (
  input wire logic link_clk,
  input wire logic link_rst,
  tws_link_if.dev link,
  input wire logic address_select_pin_0,
  input wire logic address_select_pin_1,
  input wire logic output_disable_pin,
  input wire logic [9:0] adc_result,
  output logic chip_enable_bit,
  output logic pullup_weak_active,
  output logic monitor_valid
);
  import tws_pkg::*;

  logic [1:0] line_f;
  logic [2:0] pin_f;
  logic scl_f;
  logic sda_f;
  logic scl_p_r;
  logic sda_p_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  tws_dev_state_e state_r;
  tws_dev_state_e next_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] reg_addr_r;
  logic addr_ok_r;
  logic sda_oe_r;
  logic sda_lvl_r;
  logic [7:0] regs_r [0:TWS_NUM_RW-1];
  logic [6:0] my_addr;
  logic [7:0] rd_val;
  logic byte_end;
  logic wr_pulse;
  logic [9:0] bias;

  // ****************************************
  // Line and pin synchronisers
  // ****************************************
  tws_sync #(.W(2), .RST_VAL(TWS_LINE_RST)) u_line_sync (
    .clk(link_clk),
    .rst(link_rst),
    .din({link.scl, link.sda}),
    .dout(line_f)
  );
  tws_sync #(.W(3), .RST_VAL(TWS_PIN_RST)) u_pin_sync (
    .clk(link_clk),
    .rst(link_rst),
    .din({address_select_pin_1, address_select_pin_0, output_disable_pin}),
    .dout(pin_f)
  );
  assign scl_f = line_f[1];
  assign sda_f = line_f[0];

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_p_r <= scl_f;
      sda_p_r <= sda_f;
    end
  end

  // ****************************************
  // Bus condition detection
  // ****************************************
  assign scl_rise = scl_f & ~scl_p_r;
  assign scl_fall = ~scl_f & scl_p_r;
  assign start_det = scl_f & scl_p_r & sda_p_r & ~sda_f;
  assign stop_det = scl_f & scl_p_r & ~sda_p_r & sda_f;
  assign byte_end = scl_fall && (cnt_r == TWS_BIT_CNT_FULL);
  assign wr_pulse = (state_r == TWS_D_WDATA) && byte_end;

  // ****************************************
  // Address and read data
  // ****************************************
  always_comb begin
    my_addr = TWS_SLAVE_ADDR;
    my_addr[TWS_ASEL0_BIT] = TWS_SLAVE_ADDR[TWS_ASEL0_BIT] | ~pin_f[1];
    my_addr[TWS_ASEL1_BIT] = TWS_SLAVE_ADDR[TWS_ASEL1_BIT] | ~pin_f[2];
  end

  always_comb begin
    rd_val = 8'h00;
    if (reg_addr_r == TWS_REG_ADC_MSB) begin
      rd_val = adc_result[9:2];
    end else if (reg_addr_r == TWS_REG_ADC_LSB) begin
      rd_val = {6'h00, adc_result[1:0]};
    end else if (reg_addr_r < 8'(TWS_NUM_RW)) begin
      rd_val = regs_r[reg_addr_r[3:0]];
    end
  end

  // ****************************************
  // Transfer sequencer
  // ****************************************
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state_r <= TWS_D_IDLE;
      next_r <= TWS_D_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      reg_addr_r <= 8'h00;
      addr_ok_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      state_r <= TWS_D_ADDR;
      cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= TWS_D_IDLE;
      addr_ok_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        TWS_D_ADDR, TWS_D_REG, TWS_D_WDATA: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_f};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_end) begin
            if (state_r == TWS_D_ADDR) begin
              if (shift_r[7:1] == my_addr && (!shift_r[0] || addr_ok_r)) begin
                sda_oe_r <= 1'b1;
                state_r <= TWS_D_ACK;
                next_r <= shift_r[0] ? TWS_D_RDATA : TWS_D_REG;
                tx_r <= rd_val;
              end else begin
                state_r <= TWS_D_IGNORE;
              end
            end else if (state_r == TWS_D_REG) begin
              reg_addr_r <= shift_r;
              addr_ok_r <= 1'b1;
              sda_oe_r <= 1'b1;
              state_r <= TWS_D_ACK;
              next_r <= TWS_D_WDATA;
            end else begin
              sda_oe_r <= 1'b1;
              state_r <= TWS_D_ACK;
              next_r <= TWS_D_IGNORE;
            end
          end
        end
        TWS_D_ACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            state_r <= next_r;
            if (next_r == TWS_D_RDATA) begin
              sda_oe_r <= ~tx_r[7];
              tx_r <= {tx_r[6:0], 1'b0};
            end else begin
              sda_oe_r <= 1'b0;
            end
          end
        end
        TWS_D_RDATA: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_end) begin
            sda_oe_r <= 1'b0;
            state_r <= TWS_D_MACK;
          end else if (scl_fall) begin
            sda_oe_r <= ~tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
          end
        end
        TWS_D_MACK: begin
          if (scl_rise) begin
            state_r <= TWS_D_IGNORE;
          end
        end
        TWS_D_IDLE, TWS_D_IGNORE: begin
          sda_oe_r <= 1'b0;
        end
        default: begin
          state_r <= TWS_D_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      for (int i = 0; i < TWS_NUM_RW; i++) begin
        regs_r[i] <= TWS_REG_RST;
      end
    end else if (wr_pulse && reg_addr_r < 8'(TWS_NUM_RW)) begin
      regs_r[reg_addr_r[3:0]] <= shift_r;
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  assign bias = {regs_r[TWS_REG_BIAS_HI[3:0]],
                 regs_r[TWS_REG_BIAS_LO[3:0]][1:0]};

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      chip_enable_bit <= 1'b0;
      pullup_weak_active <= 1'b0;
      monitor_valid <= 1'b0;
      sda_lvl_r <= 1'b0;
    end else begin
      sda_lvl_r <= 1'b0;
      chip_enable_bit <= regs_r[TWS_REG_CTRL0[3:0]][TWS_CHIP_EN_BIT];
      pullup_weak_active <= regs_r[TWS_REG_CTRL1[3:0]][TWS_PULLUP_BIT]
        | ~pin_f[1] | ~pin_f[2];
      monitor_valid <= ~(regs_r[TWS_REG_ADC_SEL[3:0]][TWS_MON_SEL_HI_BIT]
        & ((bias == 10'h000) | pin_f[0]
        | ~regs_r[TWS_REG_CTRL0[3:0]][TWS_CHIP_EN_BIT]));
    end
  end

  assign link.dev_sda_oe = sda_oe_r;
  assign link.dev_sda_o = sda_lvl_r;
endmodule
`default_nettype wire

//--- rtl/tws_host.sv
/*
  Two-wire bus master driven from APB command registers.
  Assumes an APB master on clk; makes the serial clock by a divider.
*/
`timescale 1ns/10ps
`default_nettype none
module tws_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  tws_link_if.host link
);
  import tws_pkg::*;

  logic sda_f;
  logic [6:0] saddr_r;
  logic rw_r;
  logic [7:0] reg_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic busy_r;
  logic nack_r;
  logic [7:0] step_r;
  logic [1:0] ph_r;
  logic [2:0] idx_r;
  logic [3:0] bit_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic lvl_r;
  logic tick;
  logic cmd_go;
  logic acc;
  tws_host_op_e op;
  logic [7:0] tx_byte;
  logic rx_byte;
  logic [2:0] stop_idx;

  tws_sync #(.W(1), .RST_VAL(1'b1)) u_sda_sync (
    .clk(clk),
    .rst(rst),
    .din(link.sda),
    .dout(sda_f)
  );

  // ****************************************
  // APB slave
  // ****************************************
  assign acc = psel & penable & pready;
  assign cmd_go = acc & pwrite & ~pslverr & (paddr == TWS_APB_CMD);

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel & ~penable) begin
        if (paddr == TWS_APB_STATUS) begin
          prdata <= {16'h0000, rdata_r, 6'h00, nack_r, busy_r};
        end else if (paddr == TWS_APB_SADDR) begin
          prdata <= {25'h000_0000, saddr_r};
        end else if (paddr == TWS_APB_CMD) begin
          prdata <= {15'h0000, rw_r, reg_r, wdata_r};
          pslverr <= pwrite & busy_r;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      saddr_r <= TWS_SLAVE_ADDR;
      rw_r <= 1'b0;
      reg_r <= 8'h00;
      wdata_r <= 8'h00;
    end else if (cmd_go) begin
      rw_r <= pwdata[TWS_CMD_READ_BIT];
      reg_r <= pwdata[15:8];
      wdata_r <= pwdata[7:0];
    end else if (acc & pwrite & ~pslverr & (paddr == TWS_APB_SADDR)) begin
      saddr_r <= pwdata[6:0];
    end
  end

  // ****************************************
  // Transfer plan
  // ****************************************
  assign stop_idx = rw_r ? 3'h6 : 3'h4;
  assign rx_byte = rw_r && idx_r == 3'h5;

  always_comb begin
    op = TWS_H_BYTE;
    tx_byte = 8'h00;
    if (!busy_r) begin
      op = TWS_H_IDLE;
    end else if (idx_r == 3'h0 || (rw_r && idx_r == 3'h3)) begin
      op = TWS_H_START;
    end else if (idx_r == stop_idx) begin
      op = TWS_H_STOP;
    end
    case (idx_r)
      3'h1: tx_byte = {saddr_r, 1'b0};
      3'h2: tx_byte = reg_r;
      3'h3: tx_byte = wdata_r;
      3'h4: tx_byte = {saddr_r, 1'b1};
      default: tx_byte = 8'h00;
    endcase
  end

  // ****************************************
  // Serial clock divider
  // ****************************************
  assign tick = busy_r && step_r == 8'h00;

  always_ff @(posedge clk) begin
    if (rst || !busy_r || tick) begin
      step_r <= TWS_STEP_LOAD;
    end else begin
      step_r <= step_r - 8'h01;
    end
  end

  // ****************************************
  // Bit sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      rdata_r <= 8'h00;
      ph_r <= 2'h0;
      idx_r <= 3'h0;
      bit_r <= 4'h0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (cmd_go) begin
      busy_r <= 1'b1;
      nack_r <= 1'b0;
      ph_r <= 2'h0;
      idx_r <= 3'h0;
      bit_r <= 4'h0;
    end else if (tick) begin
      ph_r <= ph_r + 2'h1;
      case (ph_r)
        2'h0: begin
          scl_oe_r <= 1'b1;
        end
        2'h1: begin
          if (op == TWS_H_START) begin
            sda_oe_r <= 1'b0;
          end else if (op == TWS_H_STOP) begin
            sda_oe_r <= 1'b1;
          end else if (bit_r < TWS_BIT_CNT_FULL && !rx_byte) begin
            sda_oe_r <= ~tx_byte[3'(7 - bit_r)];
          end else begin
            sda_oe_r <= 1'b0;
          end
        end
        2'h2: begin
          scl_oe_r <= 1'b0;
        end
        default: begin
          if (op == TWS_H_START) begin
            sda_oe_r <= 1'b1;
            idx_r <= idx_r + 3'h1;
          end else if (op == TWS_H_STOP) begin
            sda_oe_r <= 1'b0;
            busy_r <= 1'b0;
          end else if (bit_r < TWS_BIT_CNT_FULL) begin
            if (rx_byte) begin
              rdata_r <= {rdata_r[6:0], sda_f};
            end
            bit_r <= bit_r + 4'h1;
          end else begin
            bit_r <= 4'h0;
            if (!rx_byte && sda_f) begin
              nack_r <= 1'b1;
              idx_r <= stop_idx;
            end else begin
              idx_r <= idx_r + 3'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lvl_r <= 1'b0;
    end else begin
      lvl_r <= 1'b0;
    end
  end

  assign link.host_scl_oe = scl_oe_r;
  assign link.host_sda_oe = sda_oe_r;
  assign link.host_scl_o = lvl_r;
  assign link.host_sda_o = lvl_r;
endmodule
`default_nettype wire

//--- tb/tws_chk.sv
/*
  Checker for the two-wire link between host end and device end.
  Assumes it sits beside the link and sees its plain signals.
*/
`timescale 1ns/10ps
`default_nettype none
module tws_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic [3:0] hold_r;
  // ****************************************
  // Device end
  // ****************************************
  always_ff @(posedge link_clk) begin
    scl_q <= scl;
  end
  // Serial clock rises seen while the device holds data low
  always_ff @(posedge link_clk) begin
    if (link_rst || !dev_sda_oe) begin
      hold_r <= 4'h0;
    end else if (scl && !scl_q && hold_r != 4'hf) begin
      hold_r <= hold_r + 4'h1;
    end
  end
  a_dev_open_drain: assert property (
    @(posedge link_clk) disable iff (link_rst) dev_sda_o == 1'b0)
    else $error("device data drive level not low");
  a_dev_edge_low: assert property (
    @(posedge link_clk) disable iff (link_rst) $changed(dev_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  a_dev_ack_stable: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (dev_sda_oe && scl) |=> (dev_sda_oe || !scl))
    else $error("device released data during clock high");
  a_dev_one_byte: assert property (
    @(posedge link_clk) disable iff (link_rst) hold_r <= 4'h9)
    else $error("device held data past one byte");
  // ****************************************
  // Host end
  // ****************************************
  a_host_open_drain: assert property (
    @(posedge clk) disable iff (rst) !host_scl_o && !host_sda_o)
    else $error("host drive level not low");
  a_host_start_clock: assert property (
    @(posedge clk) disable iff (rst)
    ($rose(host_sda_oe) && scl) |-> ##[1:300] host_scl_oe)
    else $error("no clock after start");
  a_host_stop_idle: assert property (
    @(posedge clk) disable iff (rst)
    ($fell(host_sda_oe) && scl) |=> !host_scl_oe [*8])
    else $error("clock pulled right after stop");
  a_host_scl_high: assert property (
    @(posedge clk) disable iff (rst)
    $fell(host_scl_oe) |=> !host_scl_oe [*8])
    else $error("serial clock high phase too short");
  a_bus_idle_high: assert property (
    @(posedge clk) disable iff (rst)
    (!host_scl_oe && !host_sda_oe && !dev_sda_oe) |-> (scl && sda))
    else $error("released bus not high");
  c_dev_ack: cover property (@(posedge link_clk) $rose(dev_sda_oe));
  c_start: cover property (@(posedge clk) $rose(host_sda_oe) && scl);
  c_stop: cover property (@(posedge clk) $fell(host_sda_oe) && scl);
endmodule
`default_nettype wire

//--- tb/tb_top.sv
/*
  Self-checking bench: APB host end talks to the device end over the link.
  Assumes the host divides clk for the serial clock; pins are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tws_pkg::*;
  logic clk, link_clk, link_rst, psel, penable, pwrite, pready, pslverr, e;
  logic rst = 1'b1;
  logic pin0, pin1, off_pin, ce, pw, mv;
  logic [31:0] paddr, pwdata, prdata, st, q;
  logic [9:0] adc;
  logic [7:0] r1;
  int errors, tests_run, cycles, n_start, n_stop;
  tws_link_if link ();
  tws_host tws_host_inst (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  tws_device tws_device_inst (.link_clk(link_clk), .link_rst(link_rst),
    .link(link), .address_select_pin_0(pin0), .address_select_pin_1(pin1),
    .output_disable_pin(off_pin), .adc_result(adc), .chip_enable_bit(ce),
    .pullup_weak_active(pw), .monitor_valid(mv));
  tws_chk tws_chk_inst (.clk(clk), .rst(rst), .link_clk(link_clk),
    .link_rst(link_rst), .host_scl_o(link.host_scl_o),
    .host_scl_oe(link.host_scl_oe), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  always @(negedge link.sda) if (link.scl === 1'b1 && !rst) n_start++;
  always @(posedge link.sda) if (link.scl === 1'b1 && !rst) n_stop++;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      errors++;
      stop_test();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] exp_rd(input logic [7:0] r);
    exp_rd = (r == TWS_REG_ADC_MSB) ? {24'h0, adc[9:2]} : {30'h0, adc[1:0]};
  endfunction
  task automatic apb(input logic wr, input logic [31:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Start a transfer, try a refused second one, then wait for idle
  task automatic xfer(input logic rd, input logic [7:0] r,
      input logic [7:0] d);
    apb(1'b1, TWS_APB_CMD, {15'h0, rd, r, d});
    apb(1'b1, TWS_APB_CMD, {15'h0, ~rd, ~r, ~d});
    check("busy_refuse", {31'h0, e}, 32'h1);
    st = 32'h1;
    while (st[0] !== 1'b0) begin
      apb(1'b0, TWS_APB_STATUS, 32'h0);
      st = q;
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hef0c));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pin0, pin1, link_rst} = 3'h7;
    off_pin = 1'($urandom());
    adc = 10'($urandom());
    r1 = 8'($urandom()) | 8'h01;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge link_clk) link_rst <= 1'b0;
    repeat (10) @(posedge clk);
    check("enable_rst", {31'h0, ce}, 32'h0);
    check("pullup_rst", {31'h0, pw}, 32'h0);
    check("valid_rst", {31'h0, mv}, 32'h1);
    apb(1'b0, TWS_APB_SADDR, 32'h0);
    check("saddr_rst", q, {25'h0, TWS_SLAVE_ADDR});
    apb(1'b0, 32'h0000_000C, 32'h0);
    check("unmapped", {31'h0, e}, 32'h1);
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      pin0 <= (i != 0);
      pin1 <= (i == 0);
      repeat (10) @(posedge clk);
      check("pullup_pin", {31'h0, pw}, 32'h1);
      {pin0, pin1} <= 2'h3;
      repeat (10) @(posedge clk);
      check("pullup_dflt", {31'h0, pw}, 32'h0);
    end
    $display("pin test done");
    xfer(1'b0, TWS_REG_CTRL1, r1);
    check("ack_write", {31'h0, st[1]}, 32'h0);
    check("pullup_bit", {31'h0, pw}, 32'h1);
    apb(1'b1, TWS_APB_SADDR, 32'h0000_0048);
    xfer(1'b0, TWS_REG_CTRL0, 8'h80);
    check("nack_addr", {31'h0, st[1]}, 32'h1);
    check("enable_kept", {31'h0, ce}, 32'h0);
    $display("write test done");
    pin0 <= 1'b0;
    repeat (10) @(posedge clk);
    xfer(1'b0, TWS_REG_ADC_SEL, 8'h02 | 8'($urandom() & 1));
    check("ack_moved", {31'h0, st[1]}, 32'h0);
    check("mon_invalid", {31'h0, mv}, 32'h0);
    pin0 <= 1'b1;
    apb(1'b1, TWS_APB_SADDR, {25'h0, TWS_SLAVE_ADDR});
    $display("address test done");
    xfer(1'b1, TWS_REG_ADC_MSB, 8'h00);
    check("adc_msb", {24'h0, st[15:8]}, exp_rd(TWS_REG_ADC_MSB));
    xfer(1'b1, TWS_REG_ADC_LSB, 8'h00);
    check("adc_lsb", {24'h0, st[15:8]}, exp_rd(TWS_REG_ADC_LSB));
    check("starts", n_start, 7);
    check("stops", n_stop, 5);
    $display("read test done");
    stop_test();
  end
endmodule
`default_nettype wire
